// ### verilog/adcres_map.svh
`ifndef ADCRES_MAP_SVH
`define ADCRES_MAP_SVH
// byte addresses seen by the cpu
`define ADCRES_ADDR_RES_LO 16'hFF08
`define ADCRES_ADDR_RES_HI 16'hFF09
`define ADCRES_ADDR_CHAN 16'hFF0E
`define ADCRES_ADDR_T0_LO 16'hFF16
`define ADCRES_ADDR_T0_HI 16'hFF17
`define ADCRES_ADDR_T1_LO 16'hFF18
`define ADCRES_ADDR_T1_HI 16'hFF19
`define ADCRES_ADDR_HIGH_VIEW 16'hFF1A
// result width and fixed-zero padding
`define ADCRES_RES_W 10
`define ADCRES_PAD_W 6
`define ADCRES_PAD 6'h00
// reset values
`define ADCRES_RST_RES 10'h000
`define ADCRES_RST_BYTE 8'h00
// channel-select layout
`define ADCRES_CHAN_MASK 8'h3F
`define ADCRES_CHAN_LSB 0
`define ADCRES_CHAN_MSB 3
`define ADCRES_METHOD_LSB 4
`define ADCRES_METHOD_MSB 5
`define ADCRES_BITSEL_MAX 3'h5
// unmapped reads answer this
`define ADCRES_UNMAPPED 16'h0000
`endif

// ### verilog/adcres_pkg.sv
package adcres_pkg;
	// start-method field encodings
	typedef enum logic [1:0] {
		ADCRES_SW_START = 2'h0,
		ADCRES_TMR0_SYNC = 2'h1,
		ADCRES_TMR1_SYNC = 2'h2,
		ADCRES_BAD_START = 2'h3
	} adcres_method_type;
	// read handshake states
	typedef enum logic [1:0] {
		ADCRES_RD_IDLE = 2'b00,
		ADCRES_RD_WAIT = 2'b01,
		ADCRES_RD_DONE = 2'b10
	} adcres_rd_state_type;
endpackage

// ### verilog/adcres_top.sv
`timescale 1ns/1ps
`include "adcres_map.svh"
module adcres_top (
	input wire logic CORE_CLK,
	input wire logic SYS_RST,
	// converter core, same clock
	input wire logic CONV_END,
	input wire logic [9:0] SAR_VALUE,
	// writes to the mode and pin configuration registers
	input wire logic MODE_REG_WR,
	input wire logic PIN_CFG_WR,
	// cpu memory access port
	input wire logic [15:0] BUS_ADDR,
	input wire logic BUS_RD,
	input wire logic BUS_WR,
	input wire logic BUS_WORD,
	input wire logic BUS_BIT,
	input wire logic [2:0] BUS_BIT_SEL,
	input wire logic [7:0] BUS_WDATA,
	output logic [15:0] BUS_RDATA,
	output logic BUS_RVALID,
	output logic BUS_WAIT,
	// decoded channel and start method, and the stale marker
	output logic [3:0] CHANNEL_SEL,
	output adcres_pkg::adcres_method_type START_METHOD,
	output logic RESULT_STALE
);
	import adcres_pkg::*;

	// general result word, ten live bits
	logic [`ADCRES_RES_W-1:0] conv_result_word_r;
	// separate byte views
	logic [7:0] conv_result_high_byte_r;
	logic [7:0] conv_result_low_byte_r;
	// timer-synchronised words and low bytes
	logic [`ADCRES_RES_W-1:0] timer0_sync_result_word_r;
	logic [`ADCRES_RES_W-1:0] timer1_sync_result_word_r;
	logic [7:0] timer0_sync_result_low_r;
	logic [7:0] timer1_sync_result_low_r;
	// channel select register, top two bits always zero
	logic [7:0] channel_select_reg_r;
	logic [7:0] channel_select_reg_nxt;
	// read path
	adcres_rd_state_type rd_state_r;
	logic [15:0] rd_addr_r;
	logic rd_word_r;
	logic [15:0] rd_data_nxt;
	logic [15:0] rdata_r;
	logic rvalid_r;
	logic wait_r;
	// stale marker
	logic stale_r;
	// decoded strobes
	logic rd_take;
	logic chan_wr;
	logic cfg_touch;
	adcres_method_type method;

	// pad a ten-bit result out to the bus word
	function automatic logic [15:0] pad_word(input logic [`ADCRES_RES_W-1:0] v);
		pad_word = {`ADCRES_PAD, v};
	endfunction

	// upper two result bits as a zero-padded byte
	function automatic logic [7:0] upper_byte(input logic [`ADCRES_RES_W-1:0] v);
		upper_byte = {`ADCRES_PAD, v[`ADCRES_RES_W-1:8]};
	endfunction

	// the live start method, straight from the register
	assign method = adcres_method_type'(
		channel_select_reg_r[`ADCRES_METHOD_MSB:`ADCRES_METHOD_LSB]);
	// a read is only taken while no other is in flight
	assign rd_take = BUS_RD && (rd_state_r == ADCRES_RD_IDLE);
	assign chan_wr = BUS_WR && (BUS_ADDR == `ADCRES_ADDR_CHAN);
	// any write that can disturb the converter
	assign cfg_touch = chan_wr || MODE_REG_WR || PIN_CFG_WR;

	// general result capture
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			conv_result_word_r <= `ADCRES_RST_RES;
		end else if (CONV_END) begin
			conv_result_word_r <= SAR_VALUE;
		end
	end

	// byte views, same event as the word
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			conv_result_low_byte_r <= `ADCRES_RST_BYTE;
			conv_result_high_byte_r <= `ADCRES_RST_BYTE;
		end else if (CONV_END) begin
			conv_result_low_byte_r <= SAR_VALUE[7:0];
			conv_result_high_byte_r <= SAR_VALUE[`ADCRES_RES_W-1:2];
		end
	end

	// timer 0 synchronised capture
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			timer0_sync_result_word_r <= `ADCRES_RST_RES;
			timer0_sync_result_low_r <= `ADCRES_RST_BYTE;
		end else if (CONV_END && method == ADCRES_TMR0_SYNC) begin
			timer0_sync_result_word_r <= SAR_VALUE;
			timer0_sync_result_low_r <= SAR_VALUE[7:0];
		end
	end

	// timer 1 synchronised capture
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			timer1_sync_result_word_r <= `ADCRES_RST_RES;
			timer1_sync_result_low_r <= `ADCRES_RST_BYTE;
		end else if (CONV_END && method == ADCRES_TMR1_SYNC) begin
			timer1_sync_result_word_r <= SAR_VALUE;
			timer1_sync_result_low_r <= SAR_VALUE[7:0];
		end
	end
	// the prohibited method code captures into neither timer word,
	// so a bad setting cannot corrupt a good timer result

	// next channel select value
	always_comb begin
		channel_select_reg_nxt = channel_select_reg_r;
		if (chan_wr) begin
			if (BUS_BIT) begin
				if (BUS_BIT_SEL <= `ADCRES_BITSEL_MAX) begin
					channel_select_reg_nxt[BUS_BIT_SEL] = BUS_WDATA[0];
				end
			end else begin
				channel_select_reg_nxt = BUS_WDATA & `ADCRES_CHAN_MASK;
			end
		end
	end

	// channel select register
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			channel_select_reg_r <= `ADCRES_RST_BYTE;
		end else begin
			channel_select_reg_r <= channel_select_reg_nxt;
		end
	end
	// method changes mid-run are the software's problem: it must
	// stop conversion first, so the capture here uses the live field
	// relies on stopped converter

	// stale marker: a config write beats a same-cycle conversion end,
	// because the converter may have been disturbed by that write
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			stale_r <= 1'b0;
		end else if (cfg_touch) begin
			stale_r <= 1'b1;
		end else if (CONV_END) begin
			stale_r <= 1'b0;
		end
	end

	// read decode from the captured address
	always_comb begin
		rd_data_nxt = `ADCRES_UNMAPPED;
		if (rd_word_r) begin
			unique case ({rd_addr_r[15:1], 1'b0})
				`ADCRES_ADDR_RES_LO: rd_data_nxt = pad_word(conv_result_word_r);
				`ADCRES_ADDR_T0_LO: rd_data_nxt = pad_word(timer0_sync_result_word_r);
				`ADCRES_ADDR_T1_LO: rd_data_nxt = pad_word(timer1_sync_result_word_r);
				default: rd_data_nxt = `ADCRES_UNMAPPED;
			endcase
		end else begin
			unique case (rd_addr_r)
				`ADCRES_ADDR_RES_LO: rd_data_nxt = {8'h00, conv_result_low_byte_r};
				`ADCRES_ADDR_RES_HI: rd_data_nxt = {8'h00, upper_byte(conv_result_word_r)};
				`ADCRES_ADDR_HIGH_VIEW: rd_data_nxt = {8'h00, conv_result_high_byte_r};
				`ADCRES_ADDR_T0_LO: rd_data_nxt = {8'h00, timer0_sync_result_low_r};
				`ADCRES_ADDR_T0_HI: rd_data_nxt = {8'h00,
					upper_byte(timer0_sync_result_word_r)};
				`ADCRES_ADDR_T1_LO: rd_data_nxt = {8'h00, timer1_sync_result_low_r};
				`ADCRES_ADDR_T1_HI: rd_data_nxt = {8'h00,
					upper_byte(timer1_sync_result_word_r)};
				`ADCRES_ADDR_CHAN: rd_data_nxt = {8'h00, channel_select_reg_r};
				default: rd_data_nxt = `ADCRES_UNMAPPED;
			endcase
		end
	end

	// read sequencer: take, wait one cycle, answer
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rd_state_r <= ADCRES_RD_IDLE;
		end else begin
			unique case (rd_state_r)
				ADCRES_RD_IDLE: if (rd_take) begin
					rd_state_r <= ADCRES_RD_WAIT;
				end
				ADCRES_RD_WAIT: rd_state_r <= ADCRES_RD_DONE;
				ADCRES_RD_DONE: rd_state_r <= ADCRES_RD_IDLE;
				// code 11 is unreachable; recover to idle
				default: rd_state_r <= ADCRES_RD_IDLE;
			endcase
		end
	end

	// captured request
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rd_addr_r <= 16'h0000;
			rd_word_r <= 1'b0;
		end else if (rd_take) begin
			rd_addr_r <= BUS_ADDR;
			rd_word_r <= BUS_WORD;
		end
	end

	// answer registers; data sampled at the end of the wait cycle
	always_ff @(posedge CORE_CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rdata_r <= 16'h0000;
			rvalid_r <= 1'b0;
			wait_r <= 1'b0;
		end else begin
			wait_r <= rd_take;
			rvalid_r <= (rd_state_r == ADCRES_RD_WAIT);
			if (rd_state_r == ADCRES_RD_WAIT) begin
				rdata_r <= rd_data_nxt;
			end
		end
	end

	// outputs straight from flops
	assign BUS_RDATA = rdata_r;
	assign BUS_RVALID = rvalid_r;
	assign BUS_WAIT = wait_r;
	assign CHANNEL_SEL = channel_select_reg_r[`ADCRES_CHAN_MSB:`ADCRES_CHAN_LSB];
	assign START_METHOD = method;
	assign RESULT_STALE = stale_r;
	// conversion time is set outside and must be changed only
	// while stopped; nothing here guards it

	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (SYS_RST);

	a_word_capture: assert property (
		CONV_END |=> conv_result_word_r == $past(SAR_VALUE))
		else $error("result word missed conversion value");
	a_views_together: assert property (
		CONV_END |=> conv_result_low_byte_r == $past(SAR_VALUE[7:0])
			&& conv_result_high_byte_r == $past(SAR_VALUE[9:2]))
		else $error("byte views not updated with word");
	a_timer0_capture: assert property (
		CONV_END && method == ADCRES_TMR0_SYNC |=>
			timer0_sync_result_low_r == $past(SAR_VALUE[7:0])
			&& $stable(timer1_sync_result_word_r))
		else $error("timer 0 capture wrong");
	a_timer_hold: assert property (
		method == ADCRES_SW_START |=> $stable(timer0_sync_result_word_r)
			&& $stable(timer1_sync_result_word_r))
		else $error("timer word changed on software start");
	a_read_wait: assert property (
		rd_take |=> BUS_WAIT && !BUS_RVALID ##1 BUS_RVALID && !BUS_WAIT)
		else $error("read answered without one wait cycle");
	a_word_pad_zero: assert property (
		BUS_RVALID && rd_word_r |-> BUS_RDATA[15:10] == 6'h00)
		else $error("upper six result bits not zero");
	// data is taken at the end of the wait cycle, so compare with the word seen there
	a_high_addr: assert property (
		rd_take && !BUS_WORD && BUS_ADDR == `ADCRES_ADDR_RES_HI |=> ##1
			BUS_RVALID && BUS_RDATA == {14'h0000, $past(conv_result_word_r[9:8])})
		else $error("upper result bits at wrong address");
	a_bit_write: assert property (
		chan_wr && BUS_BIT && BUS_BIT_SEL <= 3'h5 |=>
			channel_select_reg_r[$past(BUS_BIT_SEL)] == $past(BUS_WDATA[0]))
		else $error("bit write to channel select lost");
	a_stale_set: assert property (
		MODE_REG_WR || PIN_CFG_WR |=> RESULT_STALE)
		else $error("config write did not mark results stale");
	a_chan_top_zero: assert property (
		channel_select_reg_r[7:6] == 2'h0)
		else $error("reserved channel select bits set");
	// timer 1 path, mirror of timer 0, must leave the other word alone
	a_timer1_capture: assert property (
		CONV_END && method == ADCRES_TMR1_SYNC |=>
			timer1_sync_result_low_r == $past(SAR_VALUE[7:0])
			&& timer1_sync_result_word_r == $past(SAR_VALUE)
			&& $stable(timer0_sync_result_word_r))
		else $error("timer 1 capture wrong");
	// prohibited code must never disturb a good timer result
	a_bad_method_hold: assert property (
		method == ADCRES_BAD_START |=> $stable(timer0_sync_result_word_r)
			&& $stable(timer1_sync_result_word_r))
		else $error("timer word changed on prohibited method");
	a_stale_clear: assert property (
		CONV_END && !cfg_touch |=> !RESULT_STALE)
		else $error("conversion end did not clear stale marker");

endmodule // adcres_top

// ### testbench/adcres_tb.sv
`timescale 1ns/1ps
module testbench;
	import adcres_pkg::*;
	// stimulus side of the block, all driven at falling edges
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic conv_end = 1'b0;
	logic [9:0] sar_value = 10'h000;
	logic mode_wr = 1'b0;
	logic pin_wr = 1'b0;
	logic [15:0] bus_addr = 16'h0000;
	logic bus_rd = 1'b0;
	logic bus_wr = 1'b0;
	logic bus_word = 1'b0;
	logic bus_bit = 1'b0;
	logic [2:0] bus_bit_sel = 3'h0;
	logic [7:0] bus_wdata = 8'h00;
	// observed outputs
	logic [15:0] bus_rdata;
	logic bus_rvalid;
	logic bus_wait;
	logic [3:0] channel_sel;
	adcres_method_type start_method;
	logic result_stale;
	// bookkeeping
	int fails = 0;
	int checked = 0;
	// every byte view, all zero straight out of reset
	logic [15:0] byte_addr [0:7] = '{16'hFF08, 16'hFF09, 16'hFF1A, 16'hFF16,
		16'hFF17, 16'hFF18, 16'hFF19, 16'hFF0E};

	adcres_top i_dut (
		.CORE_CLK(core_clk), .SYS_RST(sys_rst), .CONV_END(conv_end),
		.SAR_VALUE(sar_value), .MODE_REG_WR(mode_wr), .PIN_CFG_WR(pin_wr),
		.BUS_ADDR(bus_addr), .BUS_RD(bus_rd), .BUS_WR(bus_wr), .BUS_WORD(bus_word),
		.BUS_BIT(bus_bit), .BUS_BIT_SEL(bus_bit_sel), .BUS_WDATA(bus_wdata),
		.BUS_RDATA(bus_rdata), .BUS_RVALID(bus_rvalid), .BUS_WAIT(bus_wait),
		.CHANNEL_SEL(channel_sel), .START_METHOD(start_method),
		.RESULT_STALE(result_stale)
	);

	// 20 MHz core clock
	always #25 core_clk = ~core_clk;

	// compare one value, four-state exact
	task chk(input string n, input logic [15:0] s, input logic [15:0] e);
		checked++;
		if (s !== e) begin
			fails++;
			$display("unexpected %s expected %h seen %h", n, e, s);
		end
	endtask

	// single verdict point, shared with the watchdog
	task tally_and_finish;
		if (fails == 0 && checked > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// read: take, wait cycle, answer; three cycles per read
	task rd(input logic [15:0] a, input logic w, input logic [15:0] e);
		@(negedge core_clk);
		bus_addr = a;
		bus_word = w;
		bus_rd = 1'b1;
		@(negedge core_clk);
		bus_rd = 1'b0;
		chk("wait", {15'h0000, bus_wait}, 16'h0001);
		chk("rvalid", {15'h0000, bus_rvalid}, 16'h0000);
		@(negedge core_clk);
		chk("wait", {15'h0000, bus_wait}, 16'h0000);
		chk("rvalid", {15'h0000, bus_rvalid}, 16'h0001);
		chk("rdata", bus_rdata, e);
	endtask

	// write to channel select, byte or single bit
	task wr(input logic b, input logic [2:0] sel, input logic [7:0] d);
		@(negedge core_clk);
		bus_addr = 16'hFF0E;
		bus_bit = b;
		bus_bit_sel = sel;
		bus_wdata = d;
		bus_wr = 1'b1;
		@(negedge core_clk);
		bus_wr = 1'b0;
	endtask

	// one conversion-end pulse carrying a result
	task conv(input logic [9:0] v);
		@(negedge core_clk);
		sar_value = v;
		conv_end = 1'b1;
		@(negedge core_clk);
		conv_end = 1'b0;
		sar_value = ~v;
	endtask

	// pulse a config write seen from elsewhere
	task cfg(input logic m, input logic p);
		@(negedge core_clk);
		mode_wr = m;
		pin_wr = p;
		@(negedge core_clk);
		mode_wr = 1'b0;
		pin_wr = 1'b0;
	endtask

	// watchdog, far beyond the fewer than 150 cycles the tests need
	initial begin
		repeat (5000) @(posedge core_clk);
		fails++;
		tally_and_finish();
	end

	// main sequence
	initial begin
		repeat (20) @(negedge core_clk);
		sys_rst = 1'b0;
		// reset state of every view
		foreach (byte_addr[i]) rd(byte_addr[i], 1'b0, 16'h0000);
		rd(16'hFF08, 1'b1, 16'h0000);
		rd(16'hFF16, 1'b1, 16'h0000);
		rd(16'hFF18, 1'b1, 16'h0000);
		// software start: only the general result moves
		conv(10'h3A5);
		rd(16'hFF08, 1'b1, 16'h03A5);
		rd(16'hFF08, 1'b0, 16'h00A5);
		rd(16'hFF09, 1'b0, 16'h0003);
		rd(16'hFF1A, 1'b0, 16'h00E9);
		rd(16'hFF16, 1'b1, 16'h0000);
		// byte write: channel 5, timer 0 start
		wr(1'b0, 3'h0, 8'h15);
		chk("chan", {12'h000, channel_sel}, 16'h0005);
		chk("stale", {15'h0000, result_stale}, 16'h0001);
		chk("method", 16'(start_method), 16'(ADCRES_TMR0_SYNC));
		conv(10'h2C3);
		rd(16'hFF16, 1'b1, 16'h02C3);
		rd(16'hFF16, 1'b0, 16'h00C3);
		rd(16'hFF17, 1'b0, 16'h0002);
		rd(16'hFF18, 1'b1, 16'h0000);
		// bit writes move to timer 1 start
		wr(1'b1, 3'h4, 8'h00);
		wr(1'b1, 3'h5, 8'h01);
		chk("method", 16'(start_method), 16'(ADCRES_TMR1_SYNC));
		conv(10'h1FF);
		rd(16'hFF18, 1'b1, 16'h01FF);
		rd(16'hFF18, 1'b0, 16'h00FF);
		rd(16'hFF19, 1'b0, 16'h0001);
		rd(16'hFF16, 1'b1, 16'h02C3);
		// prohibited code captures into no timer word
		wr(1'b1, 3'h4, 8'h01);
		chk("method", 16'(start_method), 16'(ADCRES_BAD_START));
		conv(10'h155);
		rd(16'hFF08, 1'b1, 16'h0155);
		rd(16'hFF18, 1'b1, 16'h01FF);
		// top two channel-select bits stay zero
		wr(1'b1, 3'h6, 8'h01);
		wr(1'b0, 3'h0, 8'hFF);
		rd(16'hFF0E, 1'b0, 16'h003F);
		rd(16'hFF00, 1'b0, 16'h0000);
		// config writes flag results, a conversion clears the flag
		conv(10'h0AA);
		chk("stale", {15'h0000, result_stale}, 16'h0000);
		cfg(1'b1, 1'b0);
		chk("stale", {15'h0000, result_stale}, 16'h0001);
		conv(10'h0AA);
		chk("stale", {15'h0000, result_stale}, 16'h0000);
		cfg(1'b0, 1'b1);
		chk("stale", {15'h0000, result_stale}, 16'h0001);
		// reset in mid-run clears everything again
		@(negedge core_clk);
		sys_rst = 1'b1;
		@(negedge core_clk);
		sys_rst = 1'b0;
		rd(16'hFF08, 1'b1, 16'h0000);
		rd(16'hFF18, 1'b1, 16'h0000);
		rd(16'hFF0E, 1'b0, 16'h0000);
		tally_and_finish();
	end
endmodule // testbench
